//--- hdl/dfd_pkg.sv
// Shared constants and helpers for the drain fault diagnostic block
package dfd_pkg;

  localparam int CHANNELS = 6;
  localparam int CODE_W = 2;
  localparam int CNT_W = 16;

  // Two-bit per-channel fault codes
  localparam logic [1:0] CODE_NONE = 2'h0;
  localparam logic [1:0] CODE_OPEN_LOAD = 2'h1;
  localparam logic [1:0] CODE_SHORT_GROUND = 2'h2;
  localparam logic [1:0] CODE_SHORTED_LOAD = 2'h3;

  // Clock and default timer lengths
  localparam int CLK_PERIOD_NS = 25;
  localparam int TURN_ON_BLANK_NS = 10000;
  localparam int TURN_OFF_BLANK_NS = 10000;
  localparam int FAULT_FILTER_NS = 4000;

  // Reset values
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] LATCH_RESET = 2'h0;

  // Least time to whole clock cycles, rounded up, never below one
  function automatic int dfd_cycles(input int timeNs);
    int c;
    c = (timeNs + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dfd_cycles

  // Off-state window classification and on-state shorted-load check
  function automatic logic [1:0] dfd_classify(input logic cmdOn, input logic belowOpen, input logic belowGround,
                                              input logic aboveShort);
    logic [1:0] code;
    code = CODE_NONE;
    if (cmdOn)
    begin
      code = aboveShort ? CODE_SHORTED_LOAD : CODE_NONE;
    end
    else if (belowGround)
    begin
      code = CODE_SHORT_GROUND;
    end
    else if (belowOpen)
    begin
      code = CODE_OPEN_LOAD;
    end
    return code;
  endfunction : dfd_classify

endpackage : dfd_pkg

//--- hdl/dfd_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module dfd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,              // System clock
  input wire logic resetn,               // Async reset, active low
  input wire logic [WIDTH-1:0] asyncIn,  // Unsynchronised level
  output logic [WIDTH-1:0] syncOut       // Level in clk_sys domain
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : dfd_sync

//--- hdl/dfd_chan_timer.sv
// Per-channel blanking and filter timer producing sample strobes
`timescale 1ns/1ps
module dfd_chan_timer
  import dfd_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk_sys,                // System clock
  input wire logic resetn,                 // Async reset, active low
  input wire logic diagOn,                 // Both enables high
  input wire logic enableRise,             // Diagnostics just switched on
  input wire logic cmdOn,                  // Commanded channel state
  input wire logic [1:0] compCode,         // Live comparison class
  input wire logic [CW-1:0] onBlankCycles, // Turn-on blanking length
  input wire logic [CW-1:0] offBlankCycles,// Turn-off blanking length
  input wire logic [CW-1:0] filterCycles,  // Filter length
  output logic sampleStrobe,               // One-cycle pulse at timer end
  output logic [1:0] sampleCode            // Comparison class at timer end
);

  logic prevCmd;
  logic [1:0] prevComp;
  logic [CW-1:0] count;
  logic blanking;

  wire cmdChange = cmdOn != prevCmd;
  wire compChange = compCode != prevComp;
  wire startBlank = diagOn && (enableRise || cmdChange);
  // Filter only runs in a stable state, and only toward an abnormal class
  wire startFilter = diagOn && !startBlank && !blanking && compChange && (compCode != CODE_NONE);
  wire expire = diagOn && (count == CW'(1)) && !startBlank && !startFilter;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prevCmd <= 1'b0;
      prevComp <= CODE_NONE;
      count <= COUNT_RESET;
      blanking <= 1'b0;
      sampleStrobe <= 1'b0;
      sampleCode <= CODE_NONE;
    end
    else
    begin
      prevCmd <= cmdOn;
      prevComp <= compCode;
      sampleStrobe <= expire;
      sampleCode <= compCode;
      if (!diagOn)
      begin
        count <= COUNT_RESET;
        blanking <= 1'b0;
      end
      else if (startBlank)
      begin
        count <= cmdOn ? onBlankCycles : offBlankCycles;
        blanking <= 1'b1;
      end
      else if (startFilter)
      begin
        count <= filterCycles;
      end
      else if (count != COUNT_RESET)
      begin
        count <= count - CW'(1);
        blanking <= blanking && (count != CW'(1));
      end
    end
  end

endmodule : dfd_chan_timer

//--- hdl/dfd_diag_top.sv
// Drain fault diagnostics: classification, fault latches and open-drain flags
//
// Behaviour
// - Off channel above open reference: no fault
// - Off channel below ground reference: short ground
// - Off channel between references: open load
// - Off classification taken only at timer end
// - Either enable low disables diagnostics and bias
// - Status compare needs only primary enable
// - Status flag released if primary low/all masked
// - Status flag low on any unmasked below-open
// - Status flag released when all unmasked above
// - Both flags active-low open-drain
// - Fault flag low on unmasked fault, enables, select
// - Fault flag released if primary or select low
// - Shorted load when on, window when off
// - Unique two-bit fault code per channel
// - Continuous compare, latch only at timer end
// - Enable rise starts all blanking timers
// - Command change starts channel blanking timer
// - Abnormal at blanking end latches fault
// - Compare change starts filter, latch if abnormal; a change back to none starts no filter
// - No change means no timer, no capture
// - Codes 00 none, 01 open, 10 ground, 11 short
// - Latch holds code until valid frame ends
// - Durations shared, timers per channel
`timescale 1ns/1ps
module dfd_diag_top
  import dfd_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int ON_BLANK_NS = TURN_ON_BLANK_NS,
  parameter int OFF_BLANK_NS = TURN_OFF_BLANK_NS,
  parameter int FILTER_NS = FAULT_FILTER_NS
) (
  input wire logic clk_sys,                           // System clock, 40 MHz
  input wire logic resetn,                            // Async reset, active low
  input wire logic enable_primary,                    // Primary enable pin
  input wire logic enable_secondary,                  // Secondary enable pin
  input wire logic chip_select_n,                     // Serial chip select pin, active low
  input wire logic [NCH-1:0] parallel_channel_cmd,    // Parallel channel command pins
  input wire logic [NCH-1:0] serial_channel_cmd,      // Serial channel command bits
  input wire logic [NCH-1:0] flagMask,                // Per-channel flag mask bits
  input wire logic frameValidDone,                    // Pulse: valid serial frame completed
  input wire logic [NCH-1:0] drainBelowOpen,          // Comparator: feedback below open-load reference
  input wire logic [NCH-1:0] drainBelowGround,        // Comparator: feedback below short-ground reference
  input wire logic [NCH-1:0] drainAboveShort,         // Comparator: feedback above shorted-load reference
  output logic drain_status_flag_n_out,               // Status flag pin data, always low
  output logic drain_status_flag_n_oe,                // Status flag pin drive enable
  output logic fault_flag_n_out,                      // Fault flag pin data, always low
  output logic fault_flag_n_oe,                       // Fault flag pin drive enable
  output logic [NCH*CODE_W-1:0] channel_fault_code,   // Latched fault codes, channel 0 lowest
  output logic biasEnable                             // Drain bias sources on
);

  localparam logic [CNT_W-1:0] ON_BLANK_CYC = CNT_W'(dfd_cycles(ON_BLANK_NS));
  localparam logic [CNT_W-1:0] OFF_BLANK_CYC = CNT_W'(dfd_cycles(OFF_BLANK_NS));
  localparam logic [CNT_W-1:0] FILTER_CYC = CNT_W'(dfd_cycles(FILTER_NS));

  // Pin-side inputs pass two flops before any logic reads them
  logic enPrim;
  logic enSec;
  logic csN;
  logic [NCH-1:0] parCmd;
  logic [NCH-1:0] belowOpen;
  logic [NCH-1:0] belowGround;
  logic [NCH-1:0] aboveShort;

  // Each pin group gets its own pair of flops
  dfd_sync #(
    .WIDTH(2)
  ) u_sync_en (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn({enable_primary, enable_secondary}),
    .syncOut({enPrim, enSec})
  );

  // Select resets to 0, which only holds the fault flag off until it settles
  dfd_sync #(
    .WIDTH(1)
  ) u_sync_cs (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(chip_select_n),
    .syncOut(csN)
  );

  // Serial commands come from logic on this clock and skip the flops
  dfd_sync #(
    .WIDTH(NCH)
  ) u_sync_cmd (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(parallel_channel_cmd),
    .syncOut(parCmd)
  );

  // Comparator bits are synced one by one: a crossing may show a mixed class
  // for a cycle, which the blanking and filter timers absorb
  dfd_sync #(
    .WIDTH(NCH)
  ) u_sync_open (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(drainBelowOpen),
    .syncOut(belowOpen)
  );

  dfd_sync #(
    .WIDTH(NCH)
  ) u_sync_ground (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(drainBelowGround),
    .syncOut(belowGround)
  );

  dfd_sync #(
    .WIDTH(NCH)
  ) u_sync_short (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .asyncIn(drainAboveShort),
    .syncOut(aboveShort)
  );

  // Enable tracking: a rise of the combined enable restarts every blanking
  // timer, so a late second enable still gives the drains a full settle
  logic diagOnPrev;
  wire diagOn = enPrim && enSec;
  wire enableRise = diagOn && !diagOnPrev;
  wire csHigh = csN;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      diagOnPrev <= 1'b0;
    end
    else
    begin
      diagOnPrev <= diagOn;
    end
  end

  // Per-channel classification, timers and latches
  logic [NCH-1:0] cmdOn;
  logic [NCH-1:0] sampleStrobe;
  logic [NCH-1:0] latchSet;
  logic [NCH*CODE_W-1:0] sampleCode;
  logic [NCH*CODE_W-1:0] liveCode;
  logic [NCH*CODE_W-1:0] detectedCode;
  logic [NCH*CODE_W-1:0] next_detectedCode;
  logic [NCH*CODE_W-1:0] next_latchCode;
  logic [NCH-1:0] next_latchSet;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      // Commanded state is the OR of the parallel and serial commands
      assign cmdOn[ch] = parCmd[ch] || serial_channel_cmd[ch];

      // Window or shorted-load class chosen by commanded state
      assign liveCode[ch*CODE_W +: CODE_W] =
        dfd_classify(cmdOn[ch], belowOpen[ch], belowGround[ch], aboveShort[ch]);

      dfd_chan_timer #(
        .CW(CNT_W)
      ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .diagOn(diagOn),
        .enableRise(enableRise),
        .cmdOn(cmdOn[ch]),
        .compCode(liveCode[ch*CODE_W +: CODE_W]),
        .onBlankCycles(ON_BLANK_CYC),
        .offBlankCycles(OFF_BLANK_CYC),
        .filterCycles(FILTER_CYC),
        .sampleStrobe(sampleStrobe[ch]),
        .sampleCode(sampleCode[ch*CODE_W +: CODE_W])
      );

      // Current fault bits: updated when a timer period ends, cleared while primary is low
      wire [1:0] sampledNow = sampleCode[ch*CODE_W +: CODE_W];
      wire [1:0] detectNow = sampleStrobe[ch] ? sampledNow : detectedCode[ch*CODE_W +: CODE_W];

      assign next_detectedCode[ch*CODE_W +: CODE_W] = enPrim ? detectNow : CODE_NONE;

      // Capture when armed and a timer end shows an abnormal code
      wire capture = sampleStrobe[ch] && !latchSet[ch] && (sampledNow != CODE_NONE);
      // A completed valid frame reloads from the current fault bits, which
      // include a same-cycle timer result, so a fresh event is never lost
      wire [1:0] heldCode = channel_fault_code[ch*CODE_W +: CODE_W];
      wire [1:0] latchNext = !enPrim ? CODE_NONE :
                             frameValidDone ? detectNow :
                             capture ? sampledNow : heldCode;

      assign next_latchCode[ch*CODE_W +: CODE_W] = latchNext;
      assign next_latchSet[ch] = latchNext != CODE_NONE;
    end
  endgenerate

  // Current fault bits follow each timer result while primary is high
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      detectedCode <= '0;
    end
    else
    begin
      detectedCode <= next_detectedCode;
    end
  end

  // Fault latches keep their first capture until a valid frame ends; the
  // primary-enable clear lives in the next-state logic so reset stays constant
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_fault_code <= '0;
      latchSet <= '0;
    end
    else
    begin
      channel_fault_code <= next_latchCode;
      latchSet <= next_latchSet;
    end
  end

  // Flag requests, one bit per channel, OR-ed into the two pins
  logic [NCH-1:0] statusReq;
  logic [NCH-1:0] faultReq;

  // All masks set turns the status flag off outright
  wire allMasked = &flagMask;
  // Status watches the drains with primary alone, whatever the channel command
  wire statusActive = enPrim && !allMasked;

  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_flag
      // A masked channel can neither set nor hold either flag
      assign statusReq[ch] = belowOpen[ch] && !flagMask[ch];
      assign faultReq[ch] = next_latchSet[ch] && !flagMask[ch];
    end
  endgenerate

  // Wired-OR over the channels inside the device
  wire anyBelowOpen = |statusReq;
  wire anyFault = |faultReq;
  wire next_statusOe = statusActive && anyBelowOpen;
  // Fault flag follows the latches, not the current bits, so a fault that
  // has already gone keeps the pin low until a valid frame completes
  wire next_faultOe = anyFault && enPrim && enSec && csHigh;

  // Open-drain pins: data fixed low, only the drive enable moves
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      drain_status_flag_n_out <= 1'b0;
      drain_status_flag_n_oe <= 1'b0;
    end
    else
    begin
      drain_status_flag_n_out <= 1'b0;
      drain_status_flag_n_oe <= next_statusOe;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end
    else
    begin
      fault_flag_n_out <= 1'b0;
      fault_flag_n_oe <= next_faultOe;
    end
  end

  // Bias follows the synced enables, so it drops three edges after either falls
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      biasEnable <= 1'b0;
    end
    else
    begin
      biasEnable <= diagOn;
    end
  end

endmodule : dfd_diag_top

//--- testbench/dfd_diag_props.sv
// Concurrent checks on the drain fault diagnostic ports
`timescale 1ns/1ps
module dfd_diag_props
  import dfd_pkg::*;
#(
  parameter int NCH = CHANNELS
) (
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset
  input wire logic enable_primary, // Enable
  input wire logic enable_secondary, // Enable
  input wire logic chip_select_n, // Select
  input wire logic [NCH-1:0] parallel_channel_cmd, // Command
  input wire logic [NCH-1:0] serial_channel_cmd, // Command
  input wire logic [NCH-1:0] flagMask, // Masks
  input wire logic frameValidDone, // Frame end
  input wire logic [NCH-1:0] drainBelowOpen, // Compare
  input wire logic [NCH-1:0] drainBelowGround, // Compare
  input wire logic [NCH-1:0] drainAboveShort, // Compare
  input wire logic drain_status_flag_n_out, // Data
  input wire logic drain_status_flag_n_oe, // Drive
  input wire logic fault_flag_n_out, // Data
  input wire logic fault_flag_n_oe, // Drive
  input wire logic [NCH*CODE_W-1:0] channel_fault_code, // Codes
  input wire logic biasEnable // Bias
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Four samples cover the two-flop sync plus the output register
  sequence primOff;
    !enable_primary [*4];
  endsequence
  sequence bothOn;
    (enable_primary && enable_secondary) [*4];
  endsequence
  out_low_a: assert property (!drain_status_flag_n_out && !fault_flag_n_out) else $error("flag data high");
  stat_off_a: assert property (primOff |=> !drain_status_flag_n_oe) else $error("status on");
  mask_all_a: assert property ((&flagMask) [*4] |=> !drain_status_flag_n_oe) else $error("status on");
  stat_set_a: assert property ((enable_primary && (drainBelowOpen & ~flagMask) != 0) [*4]
    |=> drain_status_flag_n_oe) else $error("status off");
  stat_clr_a: assert property (((drainBelowOpen & ~flagMask) == 0) [*4]
    |=> !drain_status_flag_n_oe) else $error("status on");
  flt_off_a: assert property ((!enable_primary || !chip_select_n) [*4] |=> !fault_flag_n_oe)
    else $error("fault on");
  flt_set_a: assert property ((enable_primary && enable_secondary && chip_select_n && !flagMask[0]
    && !frameValidDone && channel_fault_code[1:0] != 2'h0) [*4] |=> fault_flag_n_oe)
    else $error("fault off");
  bias_off_a: assert property ((!enable_primary || !enable_secondary) [*4] |=> !biasEnable)
    else $error("bias on");
  bias_on_a: assert property (bothOn |=> biasEnable) else $error("bias off");
  code_clr_a: assert property (primOff |=> channel_fault_code == '0) else $error("codes kept");
  no_early_a: assert property ($rose(enable_primary && enable_secondary) && channel_fault_code == '0
    |=> (channel_fault_code == '0) [*4]) else $error("early latch");
  lat_hold_a: assert property ($past(channel_fault_code[1:0]) != 2'h0 && !$past(frameValidDone)
    && $past(enable_primary, 1) && $past(enable_primary, 4)
    |-> $stable(channel_fault_code[1:0])) else $error("latch moved");
endmodule : dfd_diag_props

//--- testbench/dfd_host_model.sv
// Host side: pull-ups on the flag wires and the valid-frame strobe
`timescale 1ns/1ps
module dfd_host_model (
  input wire logic clk_sys, // Clock
  input wire logic resetn, // Reset
  input wire logic chip_select_n, // Select level
  input wire logic statusOe, // Status drive
  input wire logic statusOut, // Status data
  input wire logic faultOe, // Fault drive
  input wire logic faultOut, // Fault data
  output logic statusPin, // Wired level
  output logic faultPin, // Wired level
  output logic frameValidDone // Frame end
);
  logic selPrev;
  // Pull-up on each flag wire, so a released flag reads high
  assign statusPin = statusOe ? statusOut : 1'b1;
  assign faultPin = faultOe ? faultOut : 1'b1;
  // Every frame counts as valid; frame errors are not modelled
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      selPrev <= 1'b1;
      frameValidDone <= 1'b0;
    end
    else
    begin
      selPrev <= chip_select_n;
      frameValidDone <= chip_select_n & ~selPrev;
    end
  end
endmodule : dfd_host_model

//--- testbench/test_dfd_diag_top.sv
// Sequence tests for the drain fault diagnostic block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errTotal++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_dfd_diag_top
  import dfd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic enable_primary = 1'b0, enable_secondary = 1'b0, chip_select_n = 1'b1;
  logic [5:0] parallel_channel_cmd = 6'h00, serial_channel_cmd = 6'h00, flagMask = 6'h00;
  logic [5:0] drainBelowOpen = 6'h00, drainBelowGround = 6'h00, drainAboveShort = 6'h00;
  logic frameValidDone, drain_status_flag_n_out, drain_status_flag_n_oe;
  logic fault_flag_n_out, fault_flag_n_oe, biasEnable, statusPin, faultPin;
  logic [11:0] channel_fault_code;
  int errTotal = 0;
  int checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  // Short timers keep each blanking and filter period at four cycles
  dfd_diag_top #(.ON_BLANK_NS(100), .OFF_BLANK_NS(100), .FILTER_NS(100)) uut (.*);
  dfd_host_model host (.clk_sys(clk_sys), .resetn(resetn), .chip_select_n(chip_select_n),
    .statusOe(drain_status_flag_n_oe), .statusOut(drain_status_flag_n_out), .faultOe(fault_flag_n_oe),
    .faultOut(fault_flag_n_out), .statusPin(statusPin), .faultPin(faultPin), .frameValidDone(frameValidDone));
  task automatic complete_run;
    if (errTotal == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic flags(input logic st, input logic ft, input logic bi);
    tick(5);
    `CHK("status", st, drain_status_flag_n_oe)
    `CHK("statusPin", ~st, statusPin)
    `CHK("fault", ft, fault_flag_n_oe)
    `CHK("faultPin", ~ft, faultPin)
    `CHK("bias", bi, biasEnable)
  endtask : flags
  task automatic waitCode(input logic [11:0] e);
    int i;
    for (i = 0; i < 40 && channel_fault_code !== e; i++)
      tick(1);
    `CHK("code", e, channel_fault_code)
    if (i == 40)
      complete_run();
  endtask : waitCode
  initial
  begin
    logic [11:0] first;
    first = {CODE_NONE, CODE_NONE, CODE_SHORTED_LOAD, CODE_NONE, CODE_OPEN_LOAD, CODE_SHORT_GROUND};
    tick(2);
    resetn = 1'b1;
    tick(2);
    // Ch0 below ground, ch1 in the window, ch3 on into a short
    drainBelowOpen = 6'h03;
    drainBelowGround = 6'h01;
    parallel_channel_cmd = 6'h08;
    drainAboveShort = 6'h08;
    enable_primary = 1'b1;
    enable_secondary = 1'b1;
    flags(1'b1, 1'b0, 1'b1);
    `CHK("early", 12'h000, channel_fault_code)
    waitCode(first);
    flags(1'b1, 1'b1, 1'b1);
    tick(20);
    `CHK("quiet", first, channel_fault_code)
    // Ch0 drifts into the window: filter runs, latch must hold
    drainBelowGround = 6'h00;
    tick(20);
    `CHK("held", first, channel_fault_code)
    drainAboveShort = 6'h0c;
    serial_channel_cmd = 6'h04;
    chip_select_n = 1'b0;
    flags(1'b1, 1'b0, 1'b1);
    tick(20);
    chip_select_n = 1'b1;
    first = {CODE_NONE, CODE_NONE, CODE_SHORTED_LOAD, CODE_SHORTED_LOAD, CODE_OPEN_LOAD, CODE_OPEN_LOAD};
    waitCode(first);
    flagMask = 6'h3f;
    flags(1'b0, 1'b0, 1'b1);
    flagMask = 6'h3e;
    flags(1'b1, 1'b1, 1'b1);
    enable_secondary = 1'b0;
    flags(1'b1, 1'b0, 1'b0);
    `CHK("kept", first, channel_fault_code)
    drainBelowOpen = 6'h02;
    flags(1'b0, 1'b0, 1'b0);
    drainBelowOpen = 6'h3f;
    enable_primary = 1'b0;
    flags(1'b0, 1'b0, 1'b0);
    `CHK("cleared", 12'h000, channel_fault_code)
    complete_run();
  end
endmodule : test_dfd_diag_top

bind dfd_diag_top dfd_diag_props #(.NCH(NCH)) chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .enable_primary(enable_primary),
  .enable_secondary(enable_secondary),
  .chip_select_n(chip_select_n),
  .parallel_channel_cmd(parallel_channel_cmd),
  .serial_channel_cmd(serial_channel_cmd),
  .flagMask(flagMask),
  .frameValidDone(frameValidDone),
  .drainBelowOpen(drainBelowOpen),
  .drainBelowGround(drainBelowGround),
  .drainAboveShort(drainAboveShort),
  .drain_status_flag_n_out(drain_status_flag_n_out),
  .drain_status_flag_n_oe(drain_status_flag_n_oe),
  .fault_flag_n_out(fault_flag_n_out),
  .fault_flag_n_oe(fault_flag_n_oe),
  .channel_fault_code(channel_fault_code),
  .biasEnable(biasEnable)
);
